// ==== src/mbh_pkg.sv ====
// Function
// - Network reads become the configured read function code 1..4, reset 4.
// - Network writes become the configured write function code 5,6,15,16, reset 16.
// - After a failed transfer wait the retry delay in centiseconds, reset 100.
// - Peripheral address is source register plus bias minus one.
// - Source registers 1..8192 only are translated; bias resets to 1. Periodic jobs skip the range check and use any start register.
// - Periodic transfers fall due once per interval counted in centiseconds.
// - Read count zero disables, one reads one, more reads consecutive registers.
// - Periodic reads start at the configured peripheral source register.
// - Read data lands in the mailbox from the configured destination register.
// - Write count zero disables, one writes one, more writes consecutive registers.
// - Periodic writes target the peripheral from the configured start register.
// - Write data comes from the mailbox from the configured source register.
// - With a unit number the route holds port drop then unit number.
// - Buffer limit is 2..16, reset 16.
package mbh_pkg;
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_READ_FC  = 12'h004;
  localparam logic [11:0] OFS_WRITE_FC = 12'h008;
  localparam logic [11:0] OFS_RETRY    = 12'h00C;
  localparam logic [11:0] OFS_BIAS     = 12'h010;
  localparam logic [11:0] OFS_INTERVAL = 12'h014;
  localparam logic [11:0] OFS_RD_COUNT = 12'h018;
  localparam logic [11:0] OFS_RD_FROM  = 12'h01C;
  localparam logic [11:0] OFS_RD_DEST  = 12'h020;
  localparam logic [11:0] OFS_WR_COUNT = 12'h024;
  localparam logic [11:0] OFS_WR_START = 12'h028;
  localparam logic [11:0] OFS_WR_FROM  = 12'h02C;
  localparam logic [11:0] OFS_ROUTE    = 12'h030;
  localparam logic [11:0] OFS_BUF_LIM  = 12'h034;
  localparam logic [11:0] OFS_STATUS   = 12'h038;
  localparam logic [11:0] OFS_INT_CLR  = 12'h03C;
  localparam logic [11:0] OFS_INT_EN   = 12'h040;
  localparam logic [11:0] OFS_XLATE    = 12'h044;
  localparam logic [11:0] OFS_STATE    = 12'h048;
  localparam logic [11:0] OFS_MBOX     = 12'h100;
  localparam logic [15:0] RST_READ_FC  = 16'h0004;
  localparam logic [15:0] RST_WRITE_FC = 16'h0010;
  localparam logic [15:0] RST_RETRY    = 16'h0064;
  localparam logic [15:0] RST_BIAS     = 16'h0001;
  localparam logic [15:0] RST_INTERVAL = 16'h0064;
  localparam logic [4:0]  RST_BUF_LIM  = 5'h10;
  localparam logic [4:0]  MIN_BUF_LIM  = 5'h02;
  localparam logic [15:0] SRC_REG_MAX  = 16'h2000;
  localparam logic [1:0]  MAX_RETRY    = 2'h3;
  localparam int          CLK_NS       = 50;
  localparam int          CS_NS        = 10000000;
  localparam int          CYC_PER_CS   = CS_NS / CLK_NS;
  // Status bit positions.
  localparam int ST_RD_DONE = 0;
  localparam int ST_WR_DONE = 1;
  localparam int ST_NOBUF   = 2;
  localparam int ST_FAIL    = 3;
  localparam int ST_XL_ERR  = 4;
  localparam int ST_BITS    = 5;

  typedef struct packed {
    logic [7:0]  fc;
    logic [15:0] addr;
    logic [15:0] count;
    logic        two_drops;
    logic [7:0]  drop_port;
    logic [7:0]  drop_unit;
  } mbh_req_t;

  typedef struct packed {
    logic        valid;
    logic        ok;
    logic        last;
    logic [15:0] data;
  } mbh_rsp_t;
endpackage

// ==== src/mbh_tick.sv ====
`timescale 1ns/100ps
// Divides pclk into a one-cycle pulse per centisecond.
module mbh_tick import mbh_pkg::*; #(
  parameter int CYCLES = CYC_PER_CS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  // Count down and pulse on wrap.
  always_comb begin
    cnt_next = (cnt_reg == 32'h0) ? 32'(CYCLES - 1) : cnt_reg - 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = (cnt_reg == 32'h0);

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick || (CYCLES == 1)) else $error("Tick pulse longer than one cycle.");
endmodule

// ==== src/mbh_host.sv ====
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
// Modbus host port: APB registers, mailbox, translation and auto-transfer engine.
module mbh_host import mbh_pkg::*; #(
  parameter int CS_CYCLES  = CYC_PER_CS,
  parameter int MBOX_DEPTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             per_req_valid,
  output mbh_req_t         per_req,
  input  wire logic        per_req_ready,
  input  wire mbh_rsp_t    per_rsp,
  output logic      [15:0] per_wdata,
  input  wire logic        per_wdata_take
);
  localparam int MW = $clog2(MBOX_DEPTH);
  typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT, S_RETRY} mbh_state_t;

  // Source register range check and bias addition, shared by both paths.
  function automatic logic [16:0] xlate(input logic [15:0] src, input logic [15:0] bias);
    xlate[16]   = (src == 16'h0) || (src > SRC_REG_MAX);
    xlate[15:0] = src + bias - 16'h1;
  endfunction

  function automatic logic [MW-1:0] mbox_idx(input logic [15:0] reg_no, input logic [15:0] ofs);
    logic [15:0] sum;
    sum = reg_no - 16'h1 + ofs;
    mbox_idx = sum[MW-1:0];
  endfunction

  logic             ctrl_en_reg, ctrl_en_next;
  logic [15:0]      read_fc_reg, read_fc_next, write_fc_reg, write_fc_next;
  logic [15:0]      retry_reg, retry_next, bias_reg, bias_next, intv_reg, intv_next;
  logic [15:0]      rd_cnt_reg, rd_cnt_next, rd_from_reg, rd_from_next;
  logic [15:0]      mailbox_read_dest_reg, mailbox_read_dest_next;
  logic [15:0]      wr_cnt_reg, wr_cnt_next;
  logic [15:0]      peripheral_write_start_reg, peripheral_write_start_next;
  logic [15:0]      wr_from_reg, wr_from_next;
  logic [16:0]      route_reg, route_next;
  logic [4:0]       buf_lim_reg, buf_lim_next;
  logic [ST_BITS-1:0] status_reg, status_next, int_en_reg, int_en_next;
  logic [31:0]      xl_reg, xl_next, prdata_reg, prdata_next;
  logic [15:0]      mbox_reg [MBOX_DEPTH];
  logic [15:0]      mbox_next [MBOX_DEPTH];
  mbh_state_t       st_reg, st_next;
  logic             is_wr_reg, is_wr_next, last_rd_reg, last_rd_next;
  logic [4:0]       rd_pend_reg, rd_pend_next, wr_pend_reg, wr_pend_next;
  logic [15:0]      idx_reg, idx_next, wait_reg, wait_next, intv_cnt_reg, intv_cnt_next;
  logic [1:0]       tries_reg, tries_next;
  logic             req_v_reg, req_v_next;
  mbh_req_t         req_reg, req_next;
  logic             cs_tick, due, wr_acc, rd_setup, map_hit;
  logic [5:0]       in_use;
  logic [ST_BITS-1:0] ev;
  logic [16:0]      xl_start, xl_from;

  mbh_tick #(.CYCLES(CS_CYCLES)) u_tick (.pclk(pclk), .presetn(presetn), .tick(cs_tick));

  // Translated start addresses of both periodic jobs; bit 16 is the range flag, unused here.
  assign xl_start = xlate(peripheral_write_start_reg, bias_reg);
  assign xl_from  = xlate(rd_from_reg, bias_reg);

  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign in_use   = {1'b0, rd_pend_reg} + {1'b0, wr_pend_reg};

  // Address decode; zero-wait APB, unmapped offsets answer with an error.
  always_comb begin
    map_hit = (paddr[11:8] == OFS_MBOX[11:8] && paddr[7:2] < 6'(MBOX_DEPTH)) ||
              (paddr <= OFS_STATE && paddr[1:0] == 2'h0);
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !map_hit;
  assign prdata  = prdata_reg;
  assign irq     = |(status_reg & int_en_reg);

  // Configuration, status and translation registers.
  always_comb begin
    ctrl_en_next = ctrl_en_reg;
    read_fc_next = read_fc_reg;
    write_fc_next = write_fc_reg;
    retry_next = retry_reg;
    bias_next = bias_reg;
    intv_next = intv_reg;
    rd_cnt_next = rd_cnt_reg;
    rd_from_next = rd_from_reg;
    mailbox_read_dest_next = mailbox_read_dest_reg;
    wr_cnt_next = wr_cnt_reg;
    peripheral_write_start_next = peripheral_write_start_reg;
    wr_from_next = wr_from_reg;
    route_next = route_reg;
    buf_lim_next = buf_lim_reg;
    int_en_next = int_en_reg;
    xl_next = xl_reg;
    status_next = status_reg;
    prdata_next = 32'h0;
    if (wr_acc) begin
      unique case (paddr)
        OFS_CTRL:     ctrl_en_next = pwdata[0];
        OFS_READ_FC:  if (pwdata[15:0] inside {[16'h1:16'h4]}) read_fc_next = pwdata[15:0];
        OFS_WRITE_FC: if (pwdata[15:0] inside {16'h5, 16'h6, 16'hF, 16'h10})
                        write_fc_next = pwdata[15:0];
        OFS_RETRY:    retry_next = pwdata[15:0];
        OFS_BIAS:     bias_next = pwdata[15:0];
        OFS_INTERVAL: intv_next = pwdata[15:0];
        OFS_RD_COUNT: rd_cnt_next = pwdata[15:0];
        OFS_RD_FROM:  rd_from_next = pwdata[15:0];
        OFS_RD_DEST:  mailbox_read_dest_next = pwdata[15:0];
        OFS_WR_COUNT: wr_cnt_next = pwdata[15:0];
        OFS_WR_START: peripheral_write_start_next = pwdata[15:0];
        OFS_WR_FROM:  wr_from_next = pwdata[15:0];
        OFS_ROUTE:    route_next = pwdata[16:0];
        OFS_BUF_LIM:  if (pwdata[4:0] >= MIN_BUF_LIM && pwdata[4:0] <= RST_BUF_LIM)
                        buf_lim_next = pwdata[4:0];
        OFS_INT_CLR:  status_next = status_reg & ~pwdata[ST_BITS-1:0];
        OFS_INT_EN:   int_en_next = pwdata[ST_BITS-1:0];
        OFS_XLATE: begin
          // Bit 16 selects a write request; the result shows code, address and range error.
          xl_next[31:24] = pwdata[16] ? write_fc_reg[7:0] : read_fc_reg[7:0];
          {xl_next[16], xl_next[15:0]} = xlate(pwdata[15:0], bias_reg);
          xl_next[23:17] = 7'h0;
        end
        default: ;
      endcase
    end
    // Events set after the clear so a coincident event is never lost.
    if (wr_acc && paddr == OFS_XLATE) begin
      status_next[ST_XL_ERR] = status_next[ST_XL_ERR] | xl_next[16];
    end
    status_next = status_next | ev;
    if (rd_setup) begin
      unique case (paddr)
        OFS_CTRL:     prdata_next = {31'h0, ctrl_en_reg};
        OFS_READ_FC:  prdata_next = {16'h0, read_fc_reg};
        OFS_WRITE_FC: prdata_next = {16'h0, write_fc_reg};
        OFS_RETRY:    prdata_next = {16'h0, retry_reg};
        OFS_BIAS:     prdata_next = {16'h0, bias_reg};
        OFS_INTERVAL: prdata_next = {16'h0, intv_reg};
        OFS_RD_COUNT: prdata_next = {16'h0, rd_cnt_reg};
        OFS_RD_FROM:  prdata_next = {16'h0, rd_from_reg};
        OFS_RD_DEST:  prdata_next = {16'h0, mailbox_read_dest_reg};
        OFS_WR_COUNT: prdata_next = {16'h0, wr_cnt_reg};
        OFS_WR_START: prdata_next = {16'h0, peripheral_write_start_reg};
        OFS_WR_FROM:  prdata_next = {16'h0, wr_from_reg};
        OFS_ROUTE:    prdata_next = {15'h0, route_reg};
        OFS_BUF_LIM:  prdata_next = {27'h0, buf_lim_reg};
        OFS_STATUS:   prdata_next = {27'h0, status_reg};
        OFS_INT_EN:   prdata_next = {27'h0, int_en_reg};
        OFS_XLATE:    prdata_next = xl_reg;
        OFS_STATE:    prdata_next = {16'h0, 6'h0, 2'(st_reg), 3'h0, in_use[4:0]};
        default:      if (paddr[11:8] == OFS_MBOX[11:8] && paddr[7:2] < 6'(MBOX_DEPTH))
                        prdata_next = {16'h0, mbox_reg[paddr[MW+1:2]]};
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_reg <= 1'b0;
      read_fc_reg <= RST_READ_FC;
      write_fc_reg <= RST_WRITE_FC;
      retry_reg <= RST_RETRY;
      bias_reg <= RST_BIAS;
      intv_reg <= RST_INTERVAL;
      rd_cnt_reg <= 16'h0;
      rd_from_reg <= 16'h1;
      mailbox_read_dest_reg <= 16'h1;
      wr_cnt_reg <= 16'h0;
      peripheral_write_start_reg <= 16'h1;
      wr_from_reg <= 16'h1;
      route_reg <= 17'h0;
      buf_lim_reg <= RST_BUF_LIM;
      status_reg <= '0;
      int_en_reg <= '0;
      xl_reg <= 32'h0;
      prdata_reg <= 32'h0;
    end else begin
      ctrl_en_reg <= ctrl_en_next;
      read_fc_reg <= read_fc_next;
      write_fc_reg <= write_fc_next;
      retry_reg <= retry_next;
      bias_reg <= bias_next;
      intv_reg <= intv_next;
      rd_cnt_reg <= rd_cnt_next;
      rd_from_reg <= rd_from_next;
      mailbox_read_dest_reg <= mailbox_read_dest_next;
      wr_cnt_reg <= wr_cnt_next;
      peripheral_write_start_reg <= peripheral_write_start_next;
      wr_from_reg <= wr_from_next;
      route_reg <= route_next;
      buf_lim_reg <= buf_lim_next;
      status_reg <= status_next;
      int_en_reg <= int_en_next;
      xl_reg <= xl_next;
      prdata_reg <= prdata_next;
    end
  end

  // Engine: interval timer, job queue counts, request issue, retries and mailbox.
  always_comb begin
    st_next = st_reg;
    is_wr_next = is_wr_reg;
    last_rd_next = last_rd_reg;
    rd_pend_next = rd_pend_reg;
    wr_pend_next = wr_pend_reg;
    idx_next = idx_reg;
    wait_next = wait_reg;
    tries_next = tries_reg;
    req_v_next = req_v_reg;
    req_next = req_reg;
    intv_cnt_next = intv_cnt_reg;
    mbox_next = mbox_reg;
    ev = '0;
    due = 1'b0;
    if (wr_acc && paddr[11:8] == OFS_MBOX[11:8] && paddr[7:2] < 6'(MBOX_DEPTH)) begin
      mbox_next[paddr[MW+1:2]] = pwdata[15:0];
    end
    if (!ctrl_en_reg || intv_reg == 16'h0) begin
      intv_cnt_next = 16'h0;
    end else if (cs_tick) begin
      due = (intv_cnt_reg + 16'h1 >= intv_reg);
      intv_cnt_next = due ? 16'h0 : intv_cnt_reg + 16'h1;
    end
    // Each due job takes a buffer; one that finds none is dropped.
    if (due && rd_cnt_reg != 16'h0) begin
      if (in_use < {1'b0, buf_lim_reg}) rd_pend_next = rd_pend_reg + 5'h1;
      else ev[ST_NOBUF] = 1'b1;
    end
    if (due && wr_cnt_reg != 16'h0) begin
      if (in_use + {5'h0, rd_cnt_reg != 16'h0} < {1'b0, buf_lim_reg})
        wr_pend_next = wr_pend_reg + 5'h1;
      else ev[ST_NOBUF] = 1'b1;
    end
    unique case (st_reg)
      S_IDLE: begin
        // Read goes first unless a read was just served and a write waits.
        if (rd_pend_reg != 5'h0 && !(last_rd_reg && wr_pend_reg != 5'h0)) begin
          is_wr_next = 1'b0;
          st_next = S_REQ;
        end else if (wr_pend_reg != 5'h0) begin
          is_wr_next = 1'b1;
          st_next = S_REQ;
        end
        tries_next = 2'h0;
        if (st_next == S_REQ) begin
          req_v_next = 1'b1;
          idx_next = 16'h0;
          req_next.fc = is_wr_next ? write_fc_reg[7:0] : read_fc_reg[7:0];
          req_next.addr = is_wr_next ? xl_start[15:0] : xl_from[15:0];
          req_next.count = is_wr_next ? wr_cnt_reg : rd_cnt_reg;
          req_next.two_drops = route_reg[16];
          req_next.drop_port = route_reg[15:8];
          req_next.drop_unit = route_reg[7:0];
        end
      end
      S_REQ: begin
        if (per_req_ready) begin
          req_v_next = 1'b0;
          st_next = S_WAIT;
        end
      end
      S_WAIT: begin
        if (is_wr_reg && per_wdata_take) idx_next = idx_reg + 16'h1;
        if (per_rsp.valid && per_rsp.ok && !is_wr_reg) begin
          mbox_next[mbox_idx(mailbox_read_dest_reg, idx_reg)] = per_rsp.data;
          idx_next = idx_reg + 16'h1;
        end
        if (per_rsp.valid && (per_rsp.last || !per_rsp.ok)) begin
          if (per_rsp.ok || tries_reg == MAX_RETRY) begin
            if (!per_rsp.ok) ev[ST_FAIL] = 1'b1;
            else if (is_wr_reg) ev[ST_WR_DONE] = 1'b1;
            else ev[ST_RD_DONE] = 1'b1;
            if (is_wr_reg) wr_pend_next = wr_pend_next - 5'h1;
            else rd_pend_next = rd_pend_next - 5'h1;
            last_rd_next = !is_wr_reg;
            st_next = S_IDLE;
          end else begin
            tries_next = tries_reg + 2'h1;
            wait_next = retry_reg;
            st_next = S_RETRY;
          end
        end
      end
      S_RETRY: begin
        if (wait_reg == 16'h0) begin
          idx_next = 16'h0;
          req_v_next = 1'b1;
          st_next = S_REQ;
        end else if (cs_tick) begin
          wait_next = wait_reg - 16'h1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= S_IDLE;
      is_wr_reg <= 1'b0;
      last_rd_reg <= 1'b0;
      rd_pend_reg <= 5'h0;
      wr_pend_reg <= 5'h0;
      idx_reg <= 16'h0;
      wait_reg <= 16'h0;
      tries_reg <= 2'h0;
      req_v_reg <= 1'b0;
      req_reg <= '0;
      intv_cnt_reg <= 16'h0;
      for (int i = 0; i < MBOX_DEPTH; i++) mbox_reg[i] <= 16'h0;
    end else begin
      st_reg <= st_next;
      is_wr_reg <= is_wr_next;
      last_rd_reg <= last_rd_next;
      rd_pend_reg <= rd_pend_next;
      wr_pend_reg <= wr_pend_next;
      idx_reg <= idx_next;
      wait_reg <= wait_next;
      tries_reg <= tries_next;
      req_v_reg <= req_v_next;
      req_reg <= req_next;
      intv_cnt_reg <= intv_cnt_next;
      mbox_reg <= mbox_next;
    end
  end

  assign per_req_valid = req_v_reg;
  assign per_req = req_reg;
  assign per_wdata = mbox_reg[mbox_idx(wr_from_reg, idx_reg)];

  a_read_fc_legal: assert property (@(posedge pclk) disable iff (!presetn)
    read_fc_reg inside {[16'h1:16'h4]}) else $error("Read code left legal set.");
  a_write_fc_legal: assert property (@(posedge pclk) disable iff (!presetn)
    write_fc_reg inside {16'h5, 16'h6, 16'hF, 16'h10}) else $error("Bad write code.");
  a_retry_wait: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == S_WAIT && st_next == S_RETRY |=> wait_reg == retry_reg)
    else $error("Retry delay not loaded.");
  a_xlate_addr: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == OFS_XLATE |=>
    xl_reg[15:0] == $past(pwdata[15:0]) + $past(bias_reg) - 16'h1)
    else $error("Translated address wrong.");
  a_xlate_range: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == OFS_XLATE && pwdata[15:0] > SRC_REG_MAX |=> xl_reg[16] && status_reg[ST_XL_ERR])
    else $error("Out of range source accepted.");
  a_zero_count: assert property (@(posedge pclk) disable iff (!presetn)
    rd_cnt_reg == 16'h0 && due |=> rd_pend_reg == $past(rd_pend_reg) - 5'(($past(st_reg) == S_WAIT
    && !$past(is_wr_reg) && $past(st_next) == S_IDLE) ? 1 : 0))
    else $error("Disabled read queued.");
  a_read_first: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == S_IDLE && rd_pend_reg != 5'h0 && !last_rd_reg |=> !is_wr_reg)
    else $error("Write issued before read.");
  a_buf_limit: assert property (@(posedge pclk) disable iff (!presetn)
    in_use <= {1'b0, buf_lim_reg} || $past(buf_lim_reg) != buf_lim_reg)
    else $error("Buffers exceed limit.");
  a_buf_lim_range: assert property (@(posedge pclk) disable iff (!presetn)
    buf_lim_reg >= MIN_BUF_LIM && buf_lim_reg <= RST_BUF_LIM)
    else $error("Buffer limit out of range.");
  a_req_hold: assert property (@(posedge pclk) disable iff (!presetn)
    per_req_valid && !per_req_ready |=> per_req_valid && $stable(per_req))
    else $error("Request dropped before taken.");
endmodule

// ==== test/mbh_periph.sv ====
`timescale 1ns/100ps
// Peripheral stand-in: answers reads with address-derived words and logs written words.
module mbh_periph import mbh_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        per_req_valid,
  input  wire mbh_req_t    per_req,
  input  wire logic [15:0] per_wdata,
  input  wire logic [3:0]  slow,
  input  wire logic        fail,
  output logic             per_req_ready,
  output mbh_rsp_t         per_rsp,
  output logic             per_wdata_take
);
  logic [15:0] wr_log [16];
  mbh_req_t    req_seen;
  int          k;

  // Outputs start quiet so the engine sees no stray answer after reset.
  initial begin
    per_req_ready  = 1'b0;
    per_rsp        = '0;
    per_wdata_take = 1'b0;
  end

  // Each word gets a pulse cycle and an idle cycle, so the engine's index has settled before
  // the next sample; slower than a real device, but it never races the engine.
  always begin
    @(posedge pclk);
    if (presetn && per_req_valid) begin
      repeat (slow) @(posedge pclk);
      per_req_ready <= 1'b1;
      req_seen = per_req;
      @(posedge pclk);
      per_req_ready <= 1'b0;
      @(posedge pclk);
      for (k = 0; k < int'(req_seen.count); k++) begin
        if (req_seen.fc < 8'h05) begin
          per_rsp <= '{1'b1, !fail, fail || k == int'(req_seen.count) - 1,
                       req_seen.addr + 16'(k)};
        end else begin
          wr_log[k[3:0]] = per_wdata;
          per_wdata_take <= 1'b1;
        end
        @(posedge pclk);
        per_rsp.valid  <= 1'b0;
        per_rsp.data   <= ~per_rsp.data;
        per_wdata_take <= 1'b0;
        @(posedge pclk);
        if (fail && req_seen.fc < 8'h05) break;
      end
      if (req_seen.fc >= 8'h05) begin
        per_rsp <= '{1'b1, !fail, 1'b1, 16'h0000};
        @(posedge pclk);
        per_rsp.valid <= 1'b0;
      end
    end
  end
endmodule

// ==== test/test_modbus_host_autotransfer.sv ====
`timescale 1ns/100ps
// Self-checking bench: register table, translation table and the auto-transfer engine.
module test_modbus_host_autotransfer import mbh_pkg::*;;
  typedef struct packed {logic wr; logic [7:0] fc; logic [15:0] src; logic [15:0] bias;} mbh_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, e;
  logic        pready, pslverr, irq, per_req_valid, per_req_ready, per_wdata_take, serr, bad;
  logic [15:0] per_wdata;
  logic [3:0]  slow = 4'h0;
  logic        fail = 1'b0;
  mbh_req_t    per_req;
  mbh_rsp_t    per_rsp;
  mbh_req_t    reqs [$];
  int          tk [$];
  int          cyc = 0, err_total = 0, check_count = 0, i, n;
  mbh_row_t    r;
  mbh_row_t    rows [10] = '{'{1'b0, 8'h01, 16'h0001, 16'h0001}, '{1'b0, 8'h02, 16'h000A, 16'h4E21},
    '{1'b0, 8'h03, 16'h2000, 16'h0000}, '{1'b0, 8'h04, 16'h0001, 16'h0000},
    '{1'b1, 8'h05, 16'h0001, 16'h0001}, '{1'b1, 8'h06, 16'h0064, 16'h0001},
    '{1'b1, 8'h0F, 16'h2000, 16'h0001}, '{1'b1, 8'h10, 16'h0002, 16'hFFFF},
    '{1'b0, 8'h04, 16'h2001, 16'h0001}, '{1'b1, 8'h10, 16'h0000, 16'h0001}};

  mbh_host #(.CS_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .per_req_valid(per_req_valid), .per_req(per_req),
    .per_req_ready(per_req_ready), .per_rsp(per_rsp), .per_wdata(per_wdata),
    .per_wdata_take(per_wdata_take));
  mbh_periph periph (.pclk(pclk), .presetn(presetn), .per_req_valid(per_req_valid),
    .per_req(per_req), .per_wdata(per_wdata), .slow(slow), .fail(fail),
    .per_req_ready(per_req_ready), .per_rsp(per_rsp), .per_wdata_take(per_wdata_take));

  always #25 pclk = ~pclk;

  // Logs every accepted request with its cycle, and cuts a hang short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (per_req_valid === 1'b1 && per_req_ready === 1'b1) begin
      reqs.push_back(per_req);
      tk.push_back(cyc);
    end
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer, entered just after a rising edge; an idle cycle follows it.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, '0);
    chk(nm, ex, rd);
  endtask

  // Polls a register until the masked bits match, with a bounded number of reads.
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    n = 0;
    do begin
      apb(1'b0, a, '0);
      n++;
    end while ((rd & m) !== v && n < 400);
  endtask

  task automatic final_report();
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Translation rows: every function code, bias wrap and both range edges.
    for (i = 0; i < 10; i++) begin
      r = rows[i];
      wr(r.wr ? OFS_WRITE_FC : OFS_READ_FC, {24'h0, r.fc});
      wr(OFS_BIAS, {16'h0, r.bias});
      wr(OFS_XLATE, {15'h0, r.wr, r.src});
      apb(1'b0, OFS_XLATE, '0);
      bad = (r.src == 16'h0000 || r.src > SRC_REG_MAX);
      e = bad ? 32'h0001_0000 : {r.fc, 7'h0, 1'b0, 16'(r.src + r.bias - 16'h0001)};
      chk("xlate", e, bad ? (rd & 32'h0001_0000) : rd);
    end
    // Reset values, refused settings and an unmapped offset.
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("read_fc", OFS_READ_FC, 32'h4);
    rdc("write_fc", OFS_WRITE_FC, 32'h10);
    rdc("retry", OFS_RETRY, 32'h64);
    rdc("bias", OFS_BIAS, 32'h1);
    rdc("interval", OFS_INTERVAL, 32'h64);
    rdc("buf_lim", OFS_BUF_LIM, 32'h10);
    wr(OFS_BUF_LIM, 32'h1);
    rdc("buf_lim_low", OFS_BUF_LIM, 32'h10);
    wr(OFS_BUF_LIM, 32'h2);
    rdc("buf_lim_min", OFS_BUF_LIM, 32'h2);
    wr(OFS_WRITE_FC, 32'h7);
    rdc("write_fc_bad", OFS_WRITE_FC, 32'h10);
    wr(OFS_READ_FC, 32'h5);
    rdc("read_fc_bad", OFS_READ_FC, 32'h4);
    apb(1'b0, 12'h050, '0);
    chk("unmapped", 32'h1, {31'h0, serr});
    // Read and write due together: read goes first, then the write.
    for (i = 0; i < 4; i++) wr(OFS_MBOX + 12'(4 * i), 32'h0000_00A0 + 32'(i));
    wr(OFS_RD_COUNT, 32'h3);
    wr(OFS_RD_FROM, 32'h5);
    wr(OFS_RD_DEST, 32'h2);
    wr(OFS_WR_COUNT, 32'h2);
    wr(OFS_WR_START, 32'h7);
    wr(OFS_WR_FROM, 32'h1);
    wr(OFS_ROUTE, 32'h0001_0A05);
    wr(OFS_INTERVAL, 32'h14);
    wr(OFS_INT_EN, 32'h3);
    slow <= 4'h3;
    wr(OFS_CTRL, 32'h1);
    poll(OFS_STATUS, 32'h2, 32'h2);
    wr(OFS_CTRL, 32'h0);
    poll(OFS_STATE, 32'h1F, 32'h0);
    chk("rd_fc", 32'h4, 32'(reqs[0].fc));
    chk("rd_addr", 32'h5, 32'(reqs[0].addr));
    chk("rd_count", 32'h3, 32'(reqs[0].count));
    chk("route", 32'h0001_0A05, {15'h0, reqs[0].two_drops, reqs[0].drop_port,
        reqs[0].drop_unit});
    chk("wr_fc", 32'h10, 32'(reqs[1].fc));
    chk("wr_addr", 32'h7, 32'(reqs[1].addr));
    chk("wr_count", 32'h2, 32'(reqs[1].count));
    chk("wr_data0", 32'hA0, {16'h0, periph.wr_log[0]});
    // The read runs first and has already put its first word into mailbox word 1.
    chk("wr_data1", 32'h5, {16'h0, periph.wr_log[1]});
    for (i = 1; i < 4; i++) rdc("mbox", OFS_MBOX + 12'(4 * i), 32'h4 + 32'(i));
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(OFS_INT_EN, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(OFS_INT_EN, 32'h3);
    wr(OFS_INT_CLR, 32'h3);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rdc("status", OFS_STATUS, 32'h0);
    // Failing read: spaced retries, then the job is dropped with the fail flag.
    fail <= 1'b1;
    slow <= 4'h0;
    wr(OFS_RETRY, 32'h2);
    wr(OFS_WR_COUNT, 32'h0);
    wr(OFS_RD_COUNT, 32'h1);
    reqs.delete();
    tk.delete();
    wr(OFS_CTRL, 32'h1);
    poll(OFS_STATUS, 32'h8, 32'h8);
    wr(OFS_CTRL, 32'h0);
    chk("tries", 32'h4, 32'(reqs.size()));
    chk("retry_gap", 32'h1, {31'h0, (tk[1] - tk[0]) >= 6 && (tk[1] - tk[0]) <= 30});
    chk("rd_single", 32'h1, 32'(reqs[0].count));
    // Write-only run: a zero read count queues no read, a count of one writes one word.
    fail <= 1'b0;
    wr(OFS_MBOX, 32'h0000_5A5A);
    wr(OFS_RD_COUNT, 32'h0);
    wr(OFS_WR_COUNT, 32'h1);
    reqs.delete();
    wr(OFS_CTRL, 32'h1);
    poll(OFS_STATUS, 32'h2, 32'h2);
    wr(OFS_CTRL, 32'h0);
    chk("wr_only", 32'h1, 32'(reqs.size()));
    chk("wr_only_fc", 32'h10, 32'(reqs[0].fc));
    chk("wr_only_data", 32'h5A5A, {16'h0, periph.wr_log[0]});
    final_report();
  end
endmodule
